// *** hdl/vps_shift_top.sv ***
// Sixteen-bit pixel shift register with input stage and register slave
`timescale 1ns/1ns
// How it works
// - Pixel edge after load strobe loads word
// - Later pixel edges shift one position each
// - Cascade input fills the vacated end
// - First data bit leaves first, bit fifteen last
// - Mid tap shows the ninth data bit
// - Freeze high stops shifting and output changes, not loads
// - After freeze, outputs change next pixel edge
// - Force pins outputs, internal bits keep shifting
// - Forced level follows forced output value
// - Load inhibit high blocks loads, not shifting
// - Inhibit low: each strobe-pixel pair loads
// - Inhibit high ignores following strobes
// - After inhibit falls, next pair loads again
// - Two mode pins select input stage mode
// - Capture per mode on write strobe
// - Queue pointers reset at power-up, mode pulse
module vps_shift_top (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // Serial side pins
   input  wire logic        pixel_shift_clock_i,
   input  wire logic        word_load_strobe_i,
   input  wire logic        cascade_serial_in_i,
   input  wire logic        shift_freeze_i,
   input  wire logic        output_force_i,
   input  wire logic        forced_output_value_i,
   input  wire logic        load_inhibit_i,
   output logic             serial_pixel_out_o,
   output logic             mid_tap_out_o,
   // Parallel side pins
   input  wire logic [15:0] parallel_data_i,
   input  wire logic        write_strobe_i,
   input  wire logic        mode_select_low_i,
   input  wire logic        mode_select_high_i,
   // AXI4-Lite write channels
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [25:0] pin_raw;
   logic [25:0] sy1_r;
   logic [25:0] sy2_r;
   logic [25:0] sy3_r;
   logic [25:0] pin_r;
   logic [25:0] rise;
   logic [25:0] fall;

   assign pin_raw = {mode_select_high_i, mode_select_low_i, load_inhibit_i,
                     forced_output_value_i, output_force_i, shift_freeze_i,
                     cascade_serial_in_i, write_strobe_i, word_load_strobe_i,
                     pixel_shift_clock_i, parallel_data_i};

   // Each pin: three stages; the filtered level moves only when the
   // second and third stage agree, so one-cycle glitches are dropped
   generate
      for (genvar i = 0; i < 26; i++) begin : g_sync
         always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sy1_r[i] <= 1'b0;
               sy2_r[i] <= 1'b0;
               sy3_r[i] <= 1'b0;
               pin_r[i] <= 1'b0;
            end else begin
               sy1_r[i] <= pin_raw[i];
               sy2_r[i] <= sy1_r[i];
               sy3_r[i] <= sy2_r[i];
               if (sy2_r[i] == sy3_r[i]) pin_r[i] <= sy3_r[i];
            end
         end
         assign rise[i] = (sy2_r[i] == sy3_r[i]) & sy3_r[i] & ~pin_r[i];
         assign fall[i] = (sy2_r[i] == sy3_r[i]) & ~sy3_r[i] & pin_r[i];
      end
   endgenerate

   // ------------------------------------------------------------------
   // Named pin levels and events
   // ------------------------------------------------------------------
   logic               pix_rise;
   logic               ld_rise;
   logic               frz;
   logic               frc;
   logic               lvl;
   logic               inh;
   logic               casc;
   vps_pkg::vps_mode_e mode;

   assign pix_rise = rise[vps_pkg::PIN_PIX];
   assign ld_rise  = rise[vps_pkg::PIN_LD];
   assign frz      = pin_r[vps_pkg::PIN_FRZ];
   assign frc      = pin_r[vps_pkg::PIN_FRC];
   assign lvl      = pin_r[vps_pkg::PIN_LVL];
   assign inh      = pin_r[vps_pkg::PIN_INH];
   assign casc     = pin_r[vps_pkg::PIN_CASC];
   // Mode low pin wins regardless of the high pin
   assign mode = pin_r[vps_pkg::PIN_M0] ? vps_pkg::VPS_MODE_TRANS :
                 pin_r[vps_pkg::PIN_M1] ? vps_pkg::VPS_MODE_QUEUE :
                                          vps_pkg::VPS_MODE_FF;

   // ------------------------------------------------------------------
   // Load request and input stage
   // ------------------------------------------------------------------
   logic        pend_r;
   logic        pend_nxt;
   logic        load_now;
   logic        q_clear;
   logic        flush_r;
   logic [15:0] stage_word;
   logic [2:0]  q_level;

   // Strobe sets the request; the next pixel edge or inhibit drops it
   assign pend_nxt = (ld_rise & ~inh) ? 1'b1 :
                     (pix_rise | inh) ? 1'b0 : pend_r;
   assign load_now = pix_rise & pend_r & ~inh;
   // Mode high pin pulsed low while load strobe is high clears queue
   assign q_clear  = (fall[vps_pkg::PIN_M1] & pin_r[vps_pkg::PIN_LD])
                   | flush_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) pend_r <= 1'b0;
      else          pend_r <= pend_nxt;
   end

   vps_input_stage u_stage (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n_i),
      .mode_i     (mode),
      .data_i     (pin_r[15:0]),
      .wr_level_i (pin_r[vps_pkg::PIN_WR]),
      .wr_rise_i  (rise[vps_pkg::PIN_WR]),
      .take_i     (load_now),
      .clear_i    (q_clear),
      .word_o     (stage_word),
      .level_o    (q_level)
   );

   // ------------------------------------------------------------------
   // Shift register and outputs
   // ------------------------------------------------------------------
   logic [15:0] sreg_r;
   logic [15:0] sreg_nxt;
   logic        step;
   logic [15:0] loads_r;

   // Load wins over shift and over freeze; data moves toward bit 0
   assign step     = load_now | (pix_rise & ~frz);
   assign sreg_nxt = load_now ? stage_word :
                     step     ? {casc, sreg_r[15:1]} :
                                sreg_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) sreg_r <= vps_pkg::WORD_RST;
      else          sreg_r <= sreg_nxt;
   end

   // Outputs register only on a step, so they hold between pixel edges
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_pixel_out_o <= 1'b0;
         mid_tap_out_o      <= 1'b0;
      end else if (step) begin
         serial_pixel_out_o <= frc ? lvl : sreg_nxt[0];
         mid_tap_out_o      <= frc ? lvl : sreg_nxt[8];
      end
   end

   // Load counter for software
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)      loads_r <= vps_pkg::WORD_RST;
      else if (load_now) loads_r <= loads_r + 16'h0001;
   end

   // ------------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------------
   vps_pkg::vps_wr_e wst_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic        wbit_r;
   logic        aw_hs;
   logic        w_hs;
   logic        wr_done;
   logic [7:0]  wr_addr;
   logic        wr_bit;
   logic        wr_map;
   logic        rd_map;
   logic [31:0] rd_mux;
   logic        ar_hs;

   // Address and data are taken in either order, response after both
   assign s_axi_awready = (wst_r == vps_pkg::VPS_WR_IDLE) & ~aw_got_r;
   assign s_axi_wready  = (wst_r == vps_pkg::VPS_WR_IDLE) & ~w_got_r;
   assign aw_hs   = s_axi_awvalid & s_axi_awready;
   assign w_hs    = s_axi_wvalid & s_axi_wready;
   assign wr_done = (aw_got_r | aw_hs) & (w_got_r | w_hs);
   assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
   assign wr_bit  = w_got_r ? wbit_r
                  : s_axi_wdata[vps_pkg::CTRL_FLUSH] & s_axi_wstrb[0];
   assign wr_map  = (wr_addr[7:4] == vps_pkg::MAP_HI);
   assign rd_map  = (s_axi_araddr[7:4] == vps_pkg::MAP_HI);
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_hs   = s_axi_arvalid & s_axi_arready;

   // Write path; flush is a one-cycle pulse, control reads back zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wst_r        <= vps_pkg::VPS_WR_IDLE;
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         awaddr_r     <= 8'h00;
         wbit_r       <= 1'b0;
         flush_r      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= vps_pkg::RESP_OKAY;
      end else begin
         flush_r <= 1'b0;
         case (wst_r)
            vps_pkg::VPS_WR_IDLE: begin
               if (wr_done) begin
                  wst_r        <= vps_pkg::VPS_WR_RESP;
                  aw_got_r     <= 1'b0;
                  w_got_r      <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_map ? vps_pkg::RESP_OKAY
                                         : vps_pkg::RESP_SLV;
                  flush_r      <= (wr_addr == vps_pkg::REG_CTRL) & wr_bit;
               end else begin
                  if (aw_hs) begin
                     aw_got_r <= 1'b1;
                     awaddr_r <= s_axi_awaddr;
                  end
                  if (w_hs) begin
                     w_got_r <= 1'b1;
                     wbit_r  <= wr_bit;
                  end
               end
            end
            vps_pkg::VPS_WR_RESP: begin
               if (s_axi_bready) begin
                  wst_r        <= vps_pkg::VPS_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: wst_r <= vps_pkg::VPS_WR_IDLE;
         endcase
      end
   end

   // Read mux; status shows queue level, pending load, freeze and mode
   always_comb begin
      case (s_axi_araddr[7:0])
         vps_pkg::REG_STATUS: rd_mux = {25'h000_0000, mode, frz, pend_r,
                                        q_level};
         vps_pkg::REG_WORD:   rd_mux = {16'h0000, sreg_r};
         vps_pkg::REG_LOADS:  rd_mux = {16'h0000, loads_r};
         default:             rd_mux = vps_pkg::DATA_ZERO;
      endcase
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= vps_pkg::DATA_ZERO;
         s_axi_rresp  <= vps_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_map ? vps_pkg::RESP_OKAY : vps_pkg::RESP_SLV;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_strobe_taken;
      ld_rise && !inh;
   endsequence

   sequence seq_plain_shift;
      pix_rise && !load_now && !frz;
   endsequence

   load_copy_a: assert property (
      load_now |=> sreg_r == $past(stage_word))
      else $error("load did not copy the stage word");

   shift_move_a: assert property (
      seq_plain_shift |=> sreg_r == {$past(casc), $past(sreg_r[15:1])})
      else $error("shift did not move one position");

   freeze_hold_a: assert property (
      (pix_rise && frz && !load_now)
      |=> $stable(sreg_r) && $stable(serial_pixel_out_o))
      else $error("register moved while frozen");

   idle_hold_a: assert property (
      !pix_rise |=> $stable(serial_pixel_out_o) && $stable(mid_tap_out_o))
      else $error("output changed without a pixel edge");

   first_bit_a: assert property (
      (load_now && !frc) |=> serial_pixel_out_o == $past(stage_word[0]))
      else $error("first bit out is not bit zero");

   mid_tap_a: assert property (
      (load_now && !frc) |=> mid_tap_out_o == $past(stage_word[8]))
      else $error("mid tap is not the ninth bit");

   force_level_a: assert property (
      (step && frc) |=> serial_pixel_out_o == $past(lvl)
                        && mid_tap_out_o == $past(lvl))
      else $error("forced outputs differ from chosen level");

   force_shift_a: assert property (
      (seq_plain_shift and frc) |=> sreg_r[14:0] == $past(sreg_r[15:1]))
      else $error("internal bits stopped under force");

   strobe_pend_a: assert property (
      seq_strobe_taken ##1 !pix_rise |-> pend_r)
      else $error("strobe edge was not held pending");

   inhibit_block_a: assert property (
      inh |=> !pend_r ##0 !$past(load_now))
      else $error("load taken while inhibited");

   pair_load_a: assert property (
      (seq_strobe_taken ##1 (pix_rise && !inh)) |-> load_now)
      else $error("strobe and pixel edge pair did not load");

endmodule

// *** hdl/vps_pkg.sv ***
// Shared constants and types for the video pixel shift register block
package vps_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned AXI_AW  = 8;
   localparam int unsigned AXI_DW  = 32;
   localparam int unsigned QDEPTH  = 4;
   localparam int unsigned QPTR_W  = 2;
   localparam int unsigned QLVL_W  = 3;
   localparam int unsigned PIN_W   = 26;
   localparam int unsigned MID_BIT = 8;

   // ------------------------------------------------------------------
   // Pin vector positions (all pins pass the three-stage synchroniser)
   // ------------------------------------------------------------------
   localparam int unsigned PIN_DATA = 0;
   localparam int unsigned PIN_PIX  = 16;
   localparam int unsigned PIN_LD   = 17;
   localparam int unsigned PIN_WR   = 18;
   localparam int unsigned PIN_CASC = 19;
   localparam int unsigned PIN_FRZ  = 20;
   localparam int unsigned PIN_FRC  = 21;
   localparam int unsigned PIN_LVL  = 22;
   localparam int unsigned PIN_INH  = 23;
   localparam int unsigned PIN_M0   = 24;
   localparam int unsigned PIN_M1   = 25;

   // ------------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ------------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_STATUS = 8'h04;
   localparam logic [7:0]  REG_WORD   = 8'h08;
   localparam logic [7:0]  REG_LOADS  = 8'h0C;
   localparam logic [3:0]  MAP_HI     = 4'h0;
   localparam int unsigned CTRL_FLUSH = 0;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
   localparam logic [15:0] WORD_RST   = 16'h0000;
   localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

   // Input stage modes, chosen by the two mode pins
   typedef enum logic [1:0] {
      VPS_MODE_FF    = 2'b00,
      VPS_MODE_QUEUE = 2'b01,
      VPS_MODE_TRANS = 2'b11
   } vps_mode_e;

   // Write channel states of the register slave
   typedef enum logic [0:0] {
      VPS_WR_IDLE = 1'b0,
      VPS_WR_RESP = 1'b1
   } vps_wr_e;

endpackage

// *** hdl/vps_input_stage.sv ***
// Parallel input stage: transparent latch, one-word and four-word queue
`timescale 1ns/1ns
module vps_input_stage (
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // Mode and parallel side
   input  vps_pkg::vps_mode_e     mode_i,
   input  wire logic [15:0]       data_i,
   input  wire logic              wr_level_i,
   input  wire logic              wr_rise_i,
   // Shift side
   input  wire logic              take_i,
   input  wire logic              clear_i,
   output logic      [15:0]       word_o,
   output logic      [2:0]        level_o
);

   logic [15:0] mem_r [0:3];
   logic [15:0] ff_r;
   logic [15:0] trans_r;
   logic [1:0]  wr_ptr_r;
   logic [1:0]  rd_ptr_r;
   logic [2:0]  level_r;
   logic        q_wr;
   logic        q_rd;
   logic        full;
   logic        empty;

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   assign q_wr  = (mode_i == vps_pkg::VPS_MODE_QUEUE) & wr_rise_i;
   assign q_rd  = (mode_i == vps_pkg::VPS_MODE_QUEUE) & take_i;
   assign full  = (level_r == 3'(vps_pkg::QDEPTH));
   assign empty = (level_r == 3'h0);
   assign level_o = level_r;

   // Queue words carry no reset; only pointers and level define state
   always_ff @(posedge clock_i) begin
      if (q_wr) begin
         mem_r[wr_ptr_r] <= data_i;
      end
   end

   // Flip-flop capture on write edge, latch follows while write is low
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ff_r    <= vps_pkg::WORD_RST;
         trans_r <= vps_pkg::WORD_RST;
      end else begin
         if (wr_rise_i) begin
            ff_r <= data_i;
         end
         if (!wr_level_i) begin
            trans_r <= data_i;
         end
      end
   end

   // Pointers reset at power-up and on the clear request
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
      end else if (clear_i) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
      end else begin
         if (q_wr) wr_ptr_r <= wr_ptr_r + 2'h1;
         if (q_rd) rd_ptr_r <= rd_ptr_r + 2'h1;
      end
   end

   // Fill level; overrunning writer overwrites, level saturates at four
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_r <= 3'h0;
      end else if (clear_i) begin
         level_r <= 3'h0;
      end else if (q_wr && !q_rd && !full) begin
         level_r <= level_r + 3'h1;
      end else if (q_rd && !q_wr && !empty) begin
         level_r <= level_r - 3'h1;
      end
   end

   // Word offered to the shift register, per mode
   always_comb begin
      case (mode_i)
         vps_pkg::VPS_MODE_TRANS: word_o = wr_level_i ? trans_r : data_i;
         vps_pkg::VPS_MODE_QUEUE: word_o = mem_r[rd_ptr_r];
         vps_pkg::VPS_MODE_FF:    word_o = ff_r;
         default:                 word_o = ff_r;
      endcase
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   queue_clear_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      clear_i |=> (level_r == 3'h0) && (rd_ptr_r == wr_ptr_r))
      else $error("queue clear did not empty the queue");

   queue_fill_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (q_wr && !q_rd && !clear_i && !full)
      |=> (level_r == $past(level_r) + 3'h1)
          && (mem_r[$past(wr_ptr_r)] == $past(data_i)))
      else $error("queue write did not store the word");

endmodule

// *** verif/vps_far_mem.sv ***
// Frame-buffer writer model feeding the parallel input stage
`timescale 1ns/1ns
module vps_far_mem (
   // Clock and request
   input  wire logic        clock_i,
   input  wire logic        go_i,
   input  wire logic [15:0] word_i,
   // Parallel side
   output logic      [15:0] data_o,
   output logic             wr_o
);
   logic [3:0] cnt_r;
   // Quiet bus at start
   initial begin
      cnt_r  = 4'h0;
      data_o = 16'h0000;
      wr_o   = 1'b0;
   end
   // One word per request, so the writer never runs ahead of loads
   // Data stands 5 clocks before the strobe rise and 1 after its fall, then turns to junk
   always @(posedge clock_i) begin
      if (go_i) begin
         cnt_r  <= 4'h1;
         data_o <= word_i;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r + 4'h1;
         wr_o  <= (cnt_r >= 4'h5) && (cnt_r < 4'hA);
         if (cnt_r == 4'hB) begin
            cnt_r  <= 4'h0;
            data_o <= ~data_o;
         end
      end
   end
endmodule

// *** verif/vps_shift_top_test.sv ***
// Self-checking bench for the pixel shift register block
`timescale 1ns/1ns
module vps_shift_top_test;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        pix = 1'b0, lds = 1'b0, casc = 1'b0, frz = 1'b0;
   logic        frc = 1'b0, fv = 1'b0, inh = 1'b0, go = 1'b0;
   logic        m0 = 1'b0, m1 = 1'b0, ser, mid, wrs, eo = 1'b0, em = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rr = 1'b0;
   logic        awr, wr_ok, bv, arr, rv;
   logic [1:0]  br, rrs;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [15:0] pd, word = 16'h0000, sr = 16'h0000;
   logic [31:0] wd = 32'h0000_0000, rd, x = 32'h0000_001E;
   logic [33:0] expq[$];
   int          mismatches = 0, checks_done = 0, loads = 0;
   event        look;

   // Free-running system clock, 50 MHz
   always #10 clock_i = ~clock_i;

   vps_shift_top i_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .pixel_shift_clock_i(pix), .word_load_strobe_i(lds),
      .cascade_serial_in_i(casc), .shift_freeze_i(frz),
      .output_force_i(frc), .forced_output_value_i(fv),
      .load_inhibit_i(inh), .serial_pixel_out_o(ser),
      .mid_tap_out_o(mid), .parallel_data_i(pd),
      .write_strobe_i(wrs), .mode_select_low_i(m0),
      .mode_select_high_i(m1), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_ok),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
      .s_axi_rready(rr));

   vps_far_mem i_far (
      .clock_i(clock_i), .go_i(go), .word_i(word),
      .data_o(pd), .wr_o(wrs));

   // Xorshift source, seeded at 30
   function automatic void rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
   endfunction

   task automatic cmp(input logic [33:0] got);
      logic [33:0] e;
      e = expq.pop_front();
      checks_done++;
      if (got !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask

   // Each answer is matched against the oldest note; error data masked
   always @(posedge clock_i) begin
      if (bv && bq)
         cmp({32'h0000_0000, br});
      if (rv && rr)
         cmp({rrs, (rrs == vps_pkg::RESP_OKAY) ? rd : 32'h0000_0000});
   end
   always @(look) cmp({32'h0000_0000, ser, mid});

   task automatic axw(input logic [7:0] a, input logic [1:0] r);
      expq.push_back({32'h0000_0000, r});
      awa <= a;
      wd <= 32'h0000_0001;
      awv <= 1'b1;
      wv <= 1'b1;
      bq <= 1'b1;
      // Waits for the answer however long; only the watchdog ends a hang
      do begin
         @(posedge clock_i);
         if (awr)
            awv <= 1'b0;
         if (wr_ok)
            wv <= 1'b0;
      end while (!bv);
      bq <= 1'b0;
      // One idle edge keeps a following call off this time step
      @(posedge clock_i);
   endtask

   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clock_i);
         if (arr)
            arv <= 1'b0;
      end while (!rv);
      rr <= 1'b0;
      @(posedge clock_i);
   endtask

   // One pixel period; outputs must stand until the edge, then follow
   task automatic step(input logic ld);
      repeat (5) @(posedge clock_i);
      expq.push_back({32'h0000_0000, eo, em});
      -> look;
      pix <= 1'b1;
      repeat (5) @(posedge clock_i);
      pix <= 1'b0;
      lds <= 1'b0;
      if (ld && !inh) begin
         // Transparent mode passes the bus, which the writer has turned
         sr = m0 ? ~word : word;
         loads++;
      end else if (!frz)
         sr = {casc, sr[15:1]};
      if ((ld && !inh) || !frz) begin
         eo = frc ? fv : sr[0];
         em = frc ? fv : sr[8];
      end
      expq.push_back({32'h0000_0000, eo, em});
      repeat (5) @(posedge clock_i);
      -> look;
   endtask

   task automatic summarize();
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Stimulus: registers, then six words with inhibit, freeze, force
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      axr(vps_pkg::REG_STATUS, 34'h0_0000_0000);
      axr(8'h10, {vps_pkg::RESP_SLV, 32'h0000_0000});
      axw(vps_pkg::REG_CTRL, vps_pkg::RESP_OKAY);
      axw(8'h14, vps_pkg::RESP_SLV);
      for (int w = 0; w < 6; w++) begin
         rnd();
         word = (w == 5) ? 16'hFFFF : x[15:0];
         inh <= (w == 2);
         m0 <= (w == 1);
         m1 <= (w >= 3);
         go <= 1'b1;
         @(posedge clock_i);
         go <= 1'b0;
         repeat (15) @(posedge clock_i);
         lds <= 1'b1;
         frz <= (w == 3);
         step(1'b1);
         inh <= 1'b0;
         for (int s = 0; s < 16; s++) begin
            rnd();
            casc <= x[0];
            frz <= x[1] & x[2];
            frc <= (w == 4) & x[3];
            fv <= x[4];
            step(1'b0);
         end
      end
      axr(vps_pkg::REG_STATUS, {29'h0000_0001, frz, 4'h0});
      axr(vps_pkg::REG_WORD, {18'h0_0000, sr});
      axr(vps_pkg::REG_LOADS, {18'h0_0000, loads[15:0]});
      summarize();
   end

   // Watchdog well beyond the expected run of about 33 us
   initial begin
      #400_000;
      mismatches++;
      summarize();
   end
endmodule
